// File: hw/cfl_flag_latch.sv
// diagnostic flag latches for the bus transceiver, read by the host over a serial port
// assumes detectors deliver asynchronous levels; the serial clock runs only while chip select is low

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - The wake-source flag is set when a bus wake event is seen and cleared when the host reads it.
// - The overtemperature flag is set while the thermal detector is high and clears only after it drops and a read.
// - A receive-pin short to ground latches a flag held until the short ends and the host has read it.
// - A receive pin stuck recessive latches a flag cleared only after recovery and a read.
// - A transmit pin held low latches a flag cleared only after recovery and a read.
// - A bus dominant beyond its timeout latches a clamp flag kept until recovery and a read.
// - The driver overcurrent flag is set while current is high and clears only after it drops and a read.
// - A suspected bus fault sets its own flag, cleared after the fault ends and a read.
// - A confirmed bus fault sets its own flag, cleared after the fault ends and a read.
// - Low bus line shorts to battery, supply and ground each have a flag set on detection, cleared after recovery and a read.
// - High bus line shorts to battery, supply and ground each have a flag set on detection, cleared after recovery and a read.
// - The receive-low flag can be left out at build time.
module cfl_flag_latch
  import cfl_pkg::*;
#(
  parameter bit RX_LOW_PRESENT = 1'b1
) (
  // core clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // serial read port
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // detector levels
  input wire logic wake_det_i,
  input wire logic otemp_det_i,
  input wire logic rx_low_det_i,
  input wire logic rx_high_det_i,
  input wire logic tx_dom_det_i,
  input wire logic bus_clamp_det_i,
  input wire logic ocur_det_i,
  input wire logic bus_fault_suspected_det_i,
  input wire logic bus_fault_confirmed_det_i,
  input wire logic canl_bat_det_i,
  input wire logic canl_vdd_det_i,
  input wire logic canl_gnd_det_i,
  input wire logic canh_bat_det_i,
  input wire logic canh_vdd_det_i,
  input wire logic canh_gnd_det_i,
  // status
  output logic flag_any_o,
  output logic read_done_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic next_flag_bit(input logic cur, input logic set, input logic clr);
    // set wins over a clear in the same cycle
    next_flag_bit = set | (cur & ~clr);
  endfunction : next_flag_bit

  ////////////////////////////////////////////////////////////////////////////////
  // crossing into the core domain

  logic [NUM_FLAGS-1:0] raw_cond;
  logic [NUM_FLAGS-1:0] cond_f;
  logic cs_n_f;
  logic rd_tgl;
  logic rd_tgl_f;
  logic [NUM_FLAGS+1:0] sync_in;
  logic [NUM_FLAGS+1:0] sync_out;

  always_comb begin
    raw_cond = FLAGS_RESET;
    raw_cond[FLG_WAKE] = wake_det_i;
    raw_cond[FLG_OTEMP] = otemp_det_i;
    raw_cond[FLG_RX_LOW] = rx_low_det_i;
    raw_cond[FLG_RX_HIGH] = rx_high_det_i;
    raw_cond[FLG_TX_DOM] = tx_dom_det_i;
    raw_cond[FLG_BUS_CLAMP] = bus_clamp_det_i;
    raw_cond[FLG_OCUR] = ocur_det_i;
    raw_cond[FLG_SUSPECT] = bus_fault_suspected_det_i;
    raw_cond[FLG_CONFIRM] = bus_fault_confirmed_det_i;
    raw_cond[FLG_L_BAT] = canl_bat_det_i;
    raw_cond[FLG_L_VDD] = canl_vdd_det_i;
    raw_cond[FLG_L_GND] = canl_gnd_det_i;
    raw_cond[FLG_H_BAT] = canh_bat_det_i;
    raw_cond[FLG_H_VDD] = canh_vdd_det_i;
    raw_cond[FLG_H_GND] = canh_gnd_det_i;
  end

  assign sync_in = {rd_tgl, cs_n_i, raw_cond};

  cfl_sync3 #(
    .WIDTH(NUM_FLAGS + 2),
    .INIT({1'b0, CS_IDLE, FLAGS_RESET})
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(sync_in),
    .filt_o(sync_out)
  );

  assign cond_f = sync_out[NUM_FLAGS-1:0];
  assign cs_n_f = sync_out[NUM_FLAGS];
  assign rd_tgl_f = sync_out[NUM_FLAGS+1];

  ////////////////////////////////////////////////////////////////////////////////
  // read event and snapshot

  logic rd_seen;
  logic rd_ev;
  logic [1:0] idle_cnt;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] snap;

  assign rd_ev = rd_tgl_f ^ rd_seen;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_seen <= 1'b0;
    end else begin
      rd_seen <= rd_tgl_f;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= 2'h0;
    end else if (!cs_n_f) begin
      idle_cnt <= 2'h0;
    end else if (idle_cnt != IDLE_CYCLES) begin
      idle_cnt <= idle_cnt + 2'h1;
    end
  end

  // frozen read image
  // snapshot only after cs has idled, so a late read toggle still clears against the word sent
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      snap <= FLAGS_RESET;
    end else if (cs_n_f && idle_cnt == IDLE_CYCLES && !rd_ev) begin
      snap <= flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flag latches

  logic wake_q;
  logic wake_rise;
  logic [NUM_FLAGS-1:0] next_flags;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= cond_f[FLG_WAKE];
    end
  end

  assign wake_rise = cond_f[FLG_WAKE] & ~wake_q;

  always_comb begin
    next_flags = flags;
    // wake set on event, cleared by read alone
    next_flags[FLG_WAKE] = next_flag_bit(flags[FLG_WAKE], wake_rise, rd_ev & snap[FLG_WAKE]);
    // level-held flags clear on read plus recovery
    // only bits in the word read are cleared
    for (int i = 1; i < NUM_FLAGS; i++) begin
      next_flags[i] = next_flag_bit(flags[i], cond_f[i], rd_ev & snap[i] & ~cond_f[i]);
    end
    // receive-low flag omitted by build option
    if (!RX_LOW_PRESENT) begin
      next_flags[FLG_RX_LOW] = 1'b0;
    end
  end

  // fault latches hold through recovery until read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_any_o <= 1'b0;
      read_done_o <= 1'b0;
    end else begin
      flag_any_o <= |next_flags;
      read_done_o <= rd_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial side, on the link clock

  logic frame_rst;
  logic [4:0] bit_cnt;
  logic [CMD_BITS-1:0] cmd_sr;
  logic [DATA_BITS-1:0] data_sr;
  logic [CMD_BITS-1:0] cmd_full;

  // chip select high ends the frame without a clock edge
  assign frame_rst = cs_n_i | ~nrst_i;
  assign cmd_full = {cmd_sr[CMD_BITS-2:0], mosi_i};

  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != CNT_FRAME_END) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      cmd_sr <= 8'h00;
    end else if (bit_cnt <= CNT_CMD_LAST) begin
      cmd_sr <= cmd_full;
    end
  end

  // snap is quasi-static here: frozen in the core domain while cs is low
  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      data_sr <= 16'h0000;
    end else if (bit_cnt == CNT_CMD_LAST) begin
      data_sr <= {{(DATA_BITS - NUM_FLAGS){1'b0}}, snap};
    end else if (bit_cnt > CNT_CMD_LAST) begin
      data_sr <= {data_sr[DATA_BITS-2:0], 1'b0};
    end
  end

  // data changes on the falling edge for sampling on the rising one
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      miso_o <= 1'b0;
    end else if (bit_cnt > CNT_CMD_LAST && bit_cnt != CNT_FRAME_END) begin
      miso_o <= data_sr[DATA_BITS-1];
    end else begin
      miso_o <= 1'b0;
    end
  end

  // read counts only for a complete frame
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_tgl <= 1'b0;
    end else if (!cs_n_i && bit_cnt == CNT_FRAME_LAST && cmd_sr == CMD_READ_FLAGS) begin
      rd_tgl <= ~rd_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  chk_wake_set: assert property ($rose(cond_f[FLG_WAKE]) |=> flags[FLG_WAKE])
    else $error("wake flag not set after wake event");

  chk_wake_clear: assert property (rd_ev && snap[FLG_WAKE] && !wake_rise |=> !flags[FLG_WAKE])
    else $error("wake flag not cleared by read");

  chk_otemp_hold: assert property (cond_f[FLG_OTEMP] |=> flags[FLG_OTEMP] ##1
    (flags[FLG_OTEMP] || ($past(rd_ev) && !$past(cond_f[FLG_OTEMP]))))
    else $error("overtemperature flag dropped while hot");

  chk_fault_clear: assert property ($fell(flags[FLG_BUS_CLAMP]) |-> $past(rd_ev) && !$past(cond_f[FLG_BUS_CLAMP]))
    else $error("clamp flag cleared without read and recovery");

  chk_txdom_clear: assert property ($fell(flags[FLG_TX_DOM]) |-> $past(rd_ev && snap[FLG_TX_DOM]))
    else $error("transmit flag cleared without a read");

  chk_short_hold: assert property (!cond_f[FLG_H_GND] && flags[FLG_H_GND] && !rd_ev |=> flags[FLG_H_GND])
    else $error("high line ground short flag lost before read");

  chk_lshort_set: assert property (cond_f[FLG_L_VDD] |=> flags[FLG_L_VDD])
    else $error("low line supply short flag not set");

  chk_rxlow_absent: assert property (!RX_LOW_PRESENT |-> !flags[FLG_RX_LOW])
    else $error("omitted receive-low flag is set");

  chk_read_keeps: assert property (rd_ev && cond_f[FLG_OCUR] |=> flags[FLG_OCUR])
    else $error("flag cleared while condition persists");

  chk_snap_frozen: assert property (!cs_n_f && $past(!cs_n_f) |-> $stable(snap))
    else $error("read image changed during frame");

  chk_miso_quiet: assert property (@(posedge sclk_i) disable iff (frame_rst) bit_cnt <= CNT_CMD_LAST |-> !miso_o)
    else $error("serial data out active during command");

  cov_read_clear: cover property ($fell(flags[FLG_CONFIRM]));
  cov_wake_read: cover property (rd_ev && snap[FLG_WAKE]);
  cov_persist: cover property (rd_ev && snap[FLG_SUSPECT] && cond_f[FLG_SUSPECT]);

endmodule : cfl_flag_latch

// File: hw/cfl_sync3.sv
// three-stage synchroniser with agreement filter for asynchronous levels
// assumes inputs come from pins or another clock; output is a registered level
module cfl_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // levels in and filtered levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] filt_o
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // only the later two stages vote; s1 feeds s2 alone
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_o <= INIT;
    end else begin
      filt_o <= (s2 & s3) | (filt_o & (s2 | s3));
    end
  end

endmodule : cfl_sync3

// File: pkg/cfl_pkg.sv
// constants for the transceiver diagnostic flag latches and their serial read port
// assumes one core clock and one serial clock that runs only inside frames
package cfl_pkg;

  // flag positions in the latch vector and in the read word
  localparam int FLG_WAKE = 0;
  localparam int FLG_OTEMP = 1;
  localparam int FLG_RX_LOW = 2;
  localparam int FLG_RX_HIGH = 3;
  localparam int FLG_TX_DOM = 4;
  localparam int FLG_BUS_CLAMP = 5;
  localparam int FLG_OCUR = 6;
  localparam int FLG_SUSPECT = 7;
  localparam int FLG_CONFIRM = 8;
  localparam int FLG_L_BAT = 9;
  localparam int FLG_L_VDD = 10;
  localparam int FLG_L_GND = 11;
  localparam int FLG_H_BAT = 12;
  localparam int FLG_H_VDD = 13;
  localparam int FLG_H_GND = 14;
  localparam int NUM_FLAGS = 15;

  // reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 15'h0000;
  localparam logic CS_IDLE = 1'b1;

  // serial frame layout: command byte, then one data word
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam logic [4:0] CNT_CMD_LAST = 5'h07;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h17;
  localparam logic [4:0] CNT_FRAME_END = 5'h18;
  localparam logic [7:0] CMD_READ_FLAGS = 8'h21;

  // synchroniser and idle timing, in core clock cycles
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] IDLE_CYCLES = 2'h2;

endpackage : cfl_pkg

// File: tb/cfl_flag_latch_tb.sv
// self-checking bench for the diagnostic flag latches
// assumes the host model drives the serial port; detectors are driven here
module cfl_flag_latch_tb
  import cfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i;
  logic nrst_i;
  logic [14:0] det;
  logic [14:0] prev_det;
  logic [14:0] exp_flags;
  logic sclk, cs_n, mosi, miso_o, flag_any_o, read_done_o;
  logic flag_any_nrx;
  int err_count = 0;
  int num_checks = 0;
  int done_cnt = 0;
  int seed_val;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (read_done_o === 1'b1) done_cnt++;
  end

  cfl_flag_latch u_cfl_flag_latch (
    .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso_o),
    .wake_det_i(det[FLG_WAKE]), .otemp_det_i(det[FLG_OTEMP]), .rx_low_det_i(det[FLG_RX_LOW]),
    .rx_high_det_i(det[FLG_RX_HIGH]), .tx_dom_det_i(det[FLG_TX_DOM]), .bus_clamp_det_i(det[FLG_BUS_CLAMP]),
    .ocur_det_i(det[FLG_OCUR]), .bus_fault_suspected_det_i(det[FLG_SUSPECT]),
    .bus_fault_confirmed_det_i(det[FLG_CONFIRM]), .canl_bat_det_i(det[FLG_L_BAT]),
    .canl_vdd_det_i(det[FLG_L_VDD]), .canl_gnd_det_i(det[FLG_L_GND]), .canh_bat_det_i(det[FLG_H_BAT]),
    .canh_vdd_det_i(det[FLG_H_VDD]), .canh_gnd_det_i(det[FLG_H_GND]),
    .flag_any_o(flag_any_o), .read_done_o(read_done_o));

  // receive-low diagnostic built out, same stimulus
  cfl_flag_latch #(.RX_LOW_PRESENT(1'b0)) u_cfl_flag_latch_nrx (
    .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(),
    .wake_det_i(det[FLG_WAKE]), .otemp_det_i(det[FLG_OTEMP]), .rx_low_det_i(det[FLG_RX_LOW]),
    .rx_high_det_i(det[FLG_RX_HIGH]), .tx_dom_det_i(det[FLG_TX_DOM]), .bus_clamp_det_i(det[FLG_BUS_CLAMP]),
    .ocur_det_i(det[FLG_OCUR]), .bus_fault_suspected_det_i(det[FLG_SUSPECT]),
    .bus_fault_confirmed_det_i(det[FLG_CONFIRM]), .canl_bat_det_i(det[FLG_L_BAT]),
    .canl_vdd_det_i(det[FLG_L_VDD]), .canl_gnd_det_i(det[FLG_L_GND]), .canh_bat_det_i(det[FLG_H_BAT]),
    .canh_vdd_det_i(det[FLG_H_VDD]), .canh_gnd_det_i(det[FLG_H_GND]),
    .flag_any_o(flag_any_nrx), .read_done_o());

  cfl_host_model u_cfl_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_o));

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // new detector levels, held long enough to pass the filter
  task automatic set_det(input logic [14:0] v);
    @(posedge clk_i);
    #1 det = v;
    repeat (8) @(posedge clk_i);
    #1;
    exp_flags = exp_flags | (v & 15'h7ffe) | {14'h0000, v[0] & ~prev_det[0]};
    prev_det = v;
    check_bit("any flag", |exp_flags, flag_any_o);
    check_bit("any flag no rx low", |(exp_flags & ~(15'h0001 << FLG_RX_LOW)), flag_any_nrx);
  endtask : set_det

  // wake clears on read alone; others only once their condition is gone
  task automatic do_read(input logic [7:0] cmd, input int edges, input bit valid);
    logic [14:0] snap;
    logic [15:0] word;
    int done0;
    snap = exp_flags;
    done0 = done_cnt;
    u_cfl_host_model.read_frame(cmd, edges, word);
    repeat (10) @(posedge clk_i);
    #1;
    check_bit("read done", 1'b1, (done_cnt == done0 + int'(valid)) ? 1'b1 : 1'b0);
    if (valid) begin
      check_word("read word", {1'b0, snap}, word);
      exp_flags = exp_flags & ~(snap & ~{det[14:1], 1'b0});
    end
    check_bit("any flag", |exp_flags, flag_any_o);
    check_bit("any flag no rx low", |(exp_flags & ~(15'h0001 << FLG_RX_LOW)), flag_any_nrx);
  endtask : do_read

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    logic [7:0] bad_cmd;
    nrst_i = 1'b0;
    det = '0;
    prev_det = '0;
    exp_flags = '0;
    seed_val = $urandom(32'h1a42);
    repeat (10) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 check_bit("any flag", 1'b0, flag_any_o);
    do_read(CMD_READ_FLAGS, 24, 1'b1);
    $display("test reset finished");
    for (int i = 0; i < NUM_FLAGS; i++) begin
      set_det(15'h0001 << i);
      do_read(CMD_READ_FLAGS, 24, 1'b1);
      do_read(CMD_READ_FLAGS, 24, 1'b1);
      set_det('0);
      do_read(CMD_READ_FLAGS, 24, 1'b1);
      do_read(CMD_READ_FLAGS, 24, 1'b1);
    end
    $display("test single flags finished");
    set_det(15'h7fff);
    set_det('0);
    bad_cmd = 8'($urandom);
    if (bad_cmd == CMD_READ_FLAGS) bad_cmd = bad_cmd ^ 8'h01;
    do_read(bad_cmd, 24, 1'b0);
    do_read(CMD_READ_FLAGS, 20, 1'b0);
    do_read(CMD_READ_FLAGS, 24, 1'b1);
    do_read(CMD_READ_FLAGS, 24, 1'b1);
    $display("test refused frames finished");
    for (int i = 0; i < 12; i++) begin
      set_det(15'($urandom));
      do_read(CMD_READ_FLAGS, 24, 1'b1);
    end
    $display("test random levels finished");
    finish_test();
  end

  initial begin
    #400us;
    err_count++;
    $display("unexpected run length: expected end seen timeout");
    finish_test();
  end
endmodule : cfl_flag_latch_tb

// File: tb/cfl_host_model.sv
// host side of the serial flag read: frames on demand, collects the read word
// assumes mode 0 timing and a 15 ns link clock that stands still between frames
module cfl_host_model (
  // serial lines to the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic read_frame(input logic [7:0] cmd, input int edges, output logic [15:0] word);
    logic [23:0] tx;
    tx = {cmd, 16'($urandom)};
    word = 16'h0000;
    cs_n_o = 1'b0;
    // select settles before the first edge
    #50;
    for (int i = 0; i < edges; i++) begin
      mosi_o = tx[23-i];
      #7.5 sclk_o = 1'b1;
      if (i >= 8) word = {word[14:0], miso_i};
      #7.5 sclk_o = 1'b0;
    end
    #10 cs_n_o = 1'b1;
    // released line carries no stale level
    mosi_o = ~mosi_o;
    #60;
  endtask : read_frame
endmodule : cfl_host_model
